//--- core/lpc_regs.vh
`ifndef LPC_REGS_VH
`define LPC_REGS_VH
// Configuration byte offsets of the three registers.
`define LPC_OFS_CMD 8'h04
`define LPC_OFS_STS 8'h06
`define LPC_OFS_REV 8'h08
// Reset values.
`define LPC_CMD_RST 16'h0000
`define LPC_STS_RST 16'h0290
// Command register writable bit positions.
`define LPC_CMD_IO 0
`define LPC_CMD_MEM 1
`define LPC_CMD_MST 2
`define LPC_CMD_MWI 4
`define LPC_CMD_PAR 6
`define LPC_CMD_SERR 8
// Mask of command bits that take writes.
`define LPC_CMD_WMASK 16'h0157
// Status event flag positions, and the capability bit at 4.
`define LPC_STS_DPE 15
`define LPC_STS_SSE 14
`define LPC_STS_MAB 13
`define LPC_STS_RTA 12
`define LPC_STS_MDP 8
`define LPC_STS_CAP 4
// Fixed status bits: medium select timing and back-to-back capable.
`define LPC_STS_FIXED 16'h0280
// Revision base value; arbitrary, not tied to any product.
`define LPC_REV_BASE 8'h00
// Width of the revision override field.
`define LPC_REV_OVR_W 3
`endif

//--- core/lpc_flag.v
`timescale 1ns/1ps
`default_nettype none
// One write-one-to-clear event flag; a set in the clear cycle wins.
module lpc_flag (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_set,
    input wire i_clr,
    output reg o_flag_q
);
    // Set has priority over clear so no event is lost.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_flag_q <= 1'b0;
        end else if (i_set) begin
            o_flag_q <= 1'b1;
        end else if (i_clr) begin
            o_flag_q <= 1'b0;
        end
    end
endmodule // lpc_flag
`default_nettype wire

//--- core/lpc_sync.v
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for a level from outside the clock domain.
module lpc_sync (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_d,
    output reg o_q
);
    reg meta_q; // First stage, read only by the second stage.
    // Shift the level through two flops.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule // lpc_sync
`default_nettype wire

//--- core/lpc_cmd_sts.v
// Overview of operation
// - System error out only when enabled.
// - Parity response off ignores parity errors.
// - Write-invalidate command only when enabled.
// - Bus mastering only when master enabled.
// - Memory decoding only when memory enabled.
// - I/O decoding only when I/O enabled.
// - Command bits 9,7,5,3 read zero.
// - Command register resets to zero.
// - Event flags clear by writing one.
// - Bit 15 sets on any parity error.
// - Bit 14 sets when system error asserted.
// - Bit 13 sets on own master abort.
// - Bit 12 sets on received target abort.
// - Never target abort; bit 11 zero.
// - Select timing field reads binary 01.
// - Bit 8 needs master, parity, response.
// - Bit 7 one, bits 6,5 zero.
// - Bit 4 follows power management support.
// - Status resets to 0290h; here 0280h until synchronised power management support sets bit 4.
// - Revision read-only, low bits overridable.
`timescale 1ns/1ps
`default_nettype none
`include "lpc_regs.vh"
module lpc_cmd_sts (
    input wire i_ref_clk,
    input wire i_rst,
    // Configuration access port: byte offset, byte enables, data.
    input wire i_cfg_rd,
    input wire i_cfg_wr,
    input wire [7:0] i_cfg_addr,
    input wire [1:0] i_cfg_be,
    input wire [15:0] i_cfg_wdata,
    output reg [15:0] o_cfg_rdata_q,
    // Datapath event inputs, same clock domain.
    input wire i_parity_err_seen,
    input wire i_serr_req,
    input wire i_master_abort,
    input wire i_target_abort_rcvd,
    input wire i_master_active,
    input wire i_master_perr,
    input wire i_mwi_req,
    // Loader values, from outside this domain.
    input wire i_pm_supported,
    input wire i_rev_ovr_valid,
    input wire [2:0] i_rev_ovr,
    // Controls toward the datapath.
    output reg o_io_decode_enable_q,
    output reg o_memory_decode_enable_q,
    output reg o_master_enable_q,
    output reg o_write_invalidate_ok_q,
    output reg o_parity_response_q,
    output reg o_hub_parity_gen_q,
    output reg o_serr_q,
    output reg o_target_abort_q
);
    reg [15:0] cmd_q; // Command register storage.
    wire pm_s; // Synchronised power management indication.
    wire ovr_v_s; // Synchronised override valid.
    wire [2:0] ovr_s; // Synchronised override field.
    wire [4:0] flags; // Event flags.
    wire [4:0] flag_set; // Event set strobes.
    wire [4:0] flag_clr; // Event clear strobes.
    reg [2:0] rev_low_q; // Latched revision low bits.
    wire [15:0] sts_word; // Assembled status word.
    wire [7:0] rev_word; // Assembled revision byte.
    wire [7:0] rev_base; // Fixed revision value before any override.
    wire wr_cmd; // Write to command register.
    wire wr_sts; // Write to status register.
    wire [15:0] bemask; // Byte lane mask.
    genvar g;

    // Decode a byte offset hit; used for both reads and writes.
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    assign bemask = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    assign wr_cmd = i_cfg_wr && hit(i_cfg_addr, `LPC_OFS_CMD);
    assign wr_sts = i_cfg_wr && hit(i_cfg_addr, `LPC_OFS_STS);

    // Loader inputs cross in through two flops each.
    lpc_sync u_pm (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_d(i_pm_supported), .o_q(pm_s));
    lpc_sync u_ov (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_d(i_rev_ovr_valid), .o_q(ovr_v_s));
    generate
        for (g = 0; g < `LPC_REV_OVR_W; g = g + 1) begin : g_ovr
            lpc_sync u_s (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_d(i_rev_ovr[g]), .o_q(ovr_s[g]));
        end
    endgenerate

    // Command register: only writable bits take data, reset clears all.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            cmd_q <= `LPC_CMD_RST;
        end else if (wr_cmd) begin
            cmd_q <= (cmd_q & ~(bemask & `LPC_CMD_WMASK)) |
                     (i_cfg_wdata & bemask & `LPC_CMD_WMASK);
        end
    end

    // Event sources; parity detection sets regardless of response control.
    assign flag_set[0] = i_parity_err_seen;
    assign flag_set[1] = o_serr_q;
    assign flag_set[2] = i_master_abort && i_master_active;
    assign flag_set[3] = i_target_abort_rcvd && i_master_active;
    assign flag_set[4] = i_master_active && i_master_perr && cmd_q[`LPC_CMD_PAR];
    assign flag_clr[0] = wr_sts && i_cfg_be[1] && i_cfg_wdata[`LPC_STS_DPE];
    assign flag_clr[1] = wr_sts && i_cfg_be[1] && i_cfg_wdata[`LPC_STS_SSE];
    assign flag_clr[2] = wr_sts && i_cfg_be[1] && i_cfg_wdata[`LPC_STS_MAB];
    assign flag_clr[3] = wr_sts && i_cfg_be[1] && i_cfg_wdata[`LPC_STS_RTA];
    assign flag_clr[4] = wr_sts && i_cfg_be[1] && i_cfg_wdata[`LPC_STS_MDP];

    // One flag per event, set wins over clear.
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_flag
            lpc_flag u_f (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_set(flag_set[g]),
                          .i_clr(flag_clr[g]), .o_flag_q(flags[g]));
        end
    endgenerate

    // Status word: event flags, fixed bits, capability bit, zeros elsewhere.
    assign sts_word = `LPC_STS_FIXED |
                      ({15'h0000, flags[0]} << `LPC_STS_DPE) |
                      ({15'h0000, flags[1]} << `LPC_STS_SSE) |
                      ({15'h0000, flags[2]} << `LPC_STS_MAB) |
                      ({15'h0000, flags[3]} << `LPC_STS_RTA) |
                      ({15'h0000, flags[4]} << `LPC_STS_MDP) |
                      ({15'h0000, pm_s} << `LPC_STS_CAP);

    // Revision low bits follow the loader when its value is valid.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            rev_low_q <= 3'h0;
        end else if (ovr_v_s) begin
            rev_low_q <= ovr_s;
        end
    end
    // Upper bits always come from the fixed value; only the low field may be replaced.
    assign rev_base = `LPC_REV_BASE;
    assign rev_word = {rev_base[7:3], rev_low_q};

    // Read data register; unmapped offsets return zero.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_cfg_rdata_q <= 16'h0000;
        end else if (i_cfg_rd) begin
            if (hit(i_cfg_addr, `LPC_OFS_CMD)) begin
                o_cfg_rdata_q <= cmd_q & `LPC_CMD_WMASK;
            end else if (hit(i_cfg_addr, `LPC_OFS_STS)) begin
                o_cfg_rdata_q <= sts_word;
            end else if (hit(i_cfg_addr, `LPC_OFS_REV)) begin
                o_cfg_rdata_q <= {8'h00, rev_word};
            end else begin
                o_cfg_rdata_q <= 16'h0000;
            end
        end
    end

    // Registered controls toward the datapath.
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_io_decode_enable_q <= 1'b0;
            o_memory_decode_enable_q <= 1'b0;
            o_master_enable_q <= 1'b0;
            o_write_invalidate_ok_q <= 1'b0;
            o_parity_response_q <= 1'b0;
            o_hub_parity_gen_q <= 1'b0;
            o_serr_q <= 1'b0;
            o_target_abort_q <= 1'b0;
        end else begin
            o_io_decode_enable_q <= cmd_q[`LPC_CMD_IO];
            o_memory_decode_enable_q <= cmd_q[`LPC_CMD_MEM];
            o_master_enable_q <= cmd_q[`LPC_CMD_MST];
            o_write_invalidate_ok_q <= cmd_q[`LPC_CMD_MWI] && cmd_q[`LPC_CMD_MST] && i_mwi_req;
            o_parity_response_q <= cmd_q[`LPC_CMD_PAR];
            o_hub_parity_gen_q <= cmd_q[`LPC_CMD_PAR];
            o_serr_q <= i_serr_req && cmd_q[`LPC_CMD_SERR];
            o_target_abort_q <= 1'b0;
        end
    end
endmodule // lpc_cmd_sts
`default_nettype wire

//--- test/lpc_cmd_sts_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the command and status registers.
module lpc_cmd_sts_chk (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cfg_rd,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [1:0] i_cfg_be,
    input wire logic [15:0] o_cfg_rdata_q,
    input wire logic i_serr_req,
    input wire logic i_mwi_req,
    input wire logic o_master_enable_q,
    input wire logic o_write_invalidate_ok_q,
    input wire logic o_parity_response_q,
    input wire logic o_hub_parity_gen_q,
    input wire logic o_serr_q,
    input wire logic o_target_abort_q
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Outputs are registered, so system error and write invalidate are tied to their causes one edge back, master enable to its write two back.
    chk_serr_cause: assert property (o_serr_q |-> $past(i_serr_req))
        else $error("system error without request");
    chk_mwi_cause: assert property (o_write_invalidate_ok_q |-> $past(i_mwi_req)
        && o_master_enable_q) else $error("write invalidate not permitted");
    chk_no_tabort: assert property (!o_target_abort_q)
        else $error("target abort signalled");
    chk_hub_parity: assert property (o_hub_parity_gen_q == o_parity_response_q)
        else $error("hub parity differs from parity response");
    chk_reset_quiet: assert property ($past(i_rst) |-> !(o_master_enable_q || o_serr_q
        || o_parity_response_q)) else $error("control active after reset");
    chk_master_cause: assert property ($rose(o_master_enable_q) |-> $past(i_cfg_wr, 2)
        && $past(i_cfg_addr, 2) == 8'h04 && $past(i_cfg_be, 2) inside {2'b01, 2'b11})
        else $error("master enable rose without command write");
    chk_status_fixed: assert property ($past(i_cfg_rd) && $past(i_cfg_addr) == 8'h06 |->
        o_cfg_rdata_q[11:9] == 3'b001 && o_cfg_rdata_q[7:5] == 3'b100
        && o_cfg_rdata_q[3:0] == 4'h0) else $error("fixed status bits wrong");
    chk_command_fixed: assert property ($past(i_cfg_rd) && $past(i_cfg_addr) == 8'h04 |->
        (o_cfg_rdata_q & 16'hfea8) == 16'h0000) else $error("fixed command bits wrong");
    chk_revision_ro: assert property ($past(i_cfg_rd) && $past(i_cfg_addr) == 8'h08 |->
        o_cfg_rdata_q[7:3] == 5'h00) else $error("revision upper bits wrong");
    cover property ($rose(o_serr_q));
    cover property ($rose(o_write_invalidate_ok_q));
    cover property ($past(i_cfg_rd) && o_cfg_rdata_q[15]);
endmodule // lpc_cmd_sts_chk
`default_nettype wire

//--- test/lpc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host bridge model issuing configuration reads and writes.
module lpc_host (
    input wire logic i_ref_clk,
    input wire logic [15:0] i_cfg_rdata_q,
    output logic o_cfg_rd,
    output logic o_cfg_wr,
    output logic [7:0] o_cfg_addr,
    output logic [1:0] o_cfg_be,
    output logic [15:0] o_cfg_wdata
);
    initial {o_cfg_rd, o_cfg_wr, o_cfg_addr, o_cfg_be, o_cfg_wdata} = '0;
    // One-cycle write; released address and data show inverted values, byte enables keep their stale ones.
    task wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        @(posedge i_ref_clk);
        {o_cfg_wr, o_cfg_addr, o_cfg_be, o_cfg_wdata} <= {1'b1, a, b, d};
        @(posedge i_ref_clk);
        {o_cfg_wr, o_cfg_addr, o_cfg_wdata} <= {1'b0, ~a, ~d};
    endtask
    // One-cycle read; data is taken once the registered answer has settled.
    task rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge i_ref_clk);
        {o_cfg_rd, o_cfg_addr} <= {1'b1, a};
        @(posedge i_ref_clk);
        {o_cfg_rd, o_cfg_addr} <= {1'b0, ~a};
        @(posedge i_ref_clk);
        #1 q = i_cfg_rdata_q;
    endtask
endmodule // lpc_host
`default_nettype wire

//--- test/lan_pci_command_status_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the command and status registers.
module lan_pci_command_status_regs_bench;
    logic clk = 0, rst = 1, perr = 0, serr = 0, mab = 0, tab = 0, act = 0, mperr = 0, mwi = 0;
    logic pm = 1;
    logic rd, wr, io, mem, mst, mwok, par, hub, so, ta;
    logic [7:0] adr;
    logic [1:0] be;
    logic [15:0] wd, rq, q;
    int mismatches = 0, n_checks = 0;
    always #50 clk = ~clk;
    lpc_host i_host (.i_ref_clk(clk), .i_cfg_rdata_q(rq), .o_cfg_rd(rd), .o_cfg_wr(wr),
        .o_cfg_addr(adr), .o_cfg_be(be), .o_cfg_wdata(wd));
    lpc_cmd_sts i_dut (.i_ref_clk(clk), .i_rst(rst), .i_cfg_rd(rd), .i_cfg_wr(wr),
        .i_cfg_addr(adr), .i_cfg_be(be), .i_cfg_wdata(wd), .o_cfg_rdata_q(rq),
        .i_parity_err_seen(perr), .i_serr_req(serr), .i_master_abort(mab),
        .i_target_abort_rcvd(tab), .i_master_active(act), .i_master_perr(mperr),
        .i_mwi_req(mwi), .i_pm_supported(pm), .i_rev_ovr_valid(1'b1), .i_rev_ovr(3'h5),
        .o_io_decode_enable_q(io), .o_memory_decode_enable_q(mem), .o_master_enable_q(mst),
        .o_write_invalidate_ok_q(mwok), .o_parity_response_q(par), .o_hub_parity_gen_q(hub),
        .o_serr_q(so), .o_target_abort_q(ta));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Waits n edges, then lets registered outputs settle.
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One-cycle pulse on parity, master abort, target abort and master parity.
    task ev(input logic [3:0] v);
        @(posedge clk);
        {perr, mab, tab, mperr} <= v;
        @(posedge clk);
        {perr, mab, tab, mperr} <= 4'h0;
        tick(1);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Reset values, read-only revision and an unmapped offset.
    task t_reset;
        i_host.rd(8'h04, q); chk(q, 16'h0000);
        i_host.rd(8'h06, q); chk(q, 16'h0290);
        i_host.wr(8'h08, 2'b11, 16'hffff);
        i_host.rd(8'h08, q); chk(q & 16'h00ff, 16'h0005);
        i_host.rd(8'h0a, q); chk(q, 16'h0000);
    endtask
    // Writable command bits drive the controls; fixed bits ignore writes.
    task t_cmd;
        @(posedge clk) mwi <= 1'b1;
        i_host.wr(8'h04, 2'b11, 16'hffff);
        i_host.rd(8'h04, q); chk(q, 16'h0157);
        chk({9'h0, io, mem, mst, mwok, par, hub, so}, 16'h007e);
        chk(ta, 1'b0);
        i_host.wr(8'h06, 2'b11, 16'hffff);
        i_host.rd(8'h06, q); chk(q, 16'h0290);
        i_host.wr(8'h04, 2'b01, 16'h0010); tick(2);
        chk({9'h0, io, mem, mst, mwok, par, hub, so}, 16'h0000);
    endtask
    // System error gated by its enable, then flagged and cleared.
    task t_serr;
        @(posedge clk) serr <= 1'b1;
        i_host.wr(8'h04, 2'b10, 16'h0000); tick(3);
        chk(so, 1'b0);
        i_host.wr(8'h06, 2'b10, 16'h4000);
        i_host.rd(8'h06, q); chk(q, 16'h0290);
        i_host.wr(8'h04, 2'b10, 16'h0100); tick(2);
        chk(so, 1'b1);
        i_host.rd(8'h06, q); chk(q, 16'h4290);
        @(posedge clk) serr <= 1'b0;
        i_host.wr(8'h06, 2'b10, 16'h4000);
        i_host.rd(8'h06, q); chk(q, 16'h0290);
    endtask
    // Event flags with parity response off and on, gated by master activity.
    task t_events;
        @(posedge clk) act <= 1'b1;
        ev(4'h9);
        i_host.rd(8'h06, q); chk(q, 16'h8290);
        @(posedge clk) act <= 1'b0;
        ev(4'h4);
        i_host.rd(8'h06, q); chk(q, 16'h8290);
        i_host.wr(8'h04, 2'b11, 16'h0040);
        @(posedge clk) act <= 1'b1;
        ev(4'h7);
        i_host.rd(8'h06, q); chk(q, 16'hb390);
        i_host.wr(8'h06, 2'b01, 16'hffff);
        i_host.rd(8'h06, q); chk(q, 16'hb390);
        i_host.wr(8'h06, 2'b10, 16'hffff);
        i_host.rd(8'h06, q); chk(q, 16'h0290);
    endtask
    // Capability bit follows the loader's power management indication.
    task t_caps;
        @(posedge clk) pm <= 1'b0;
        tick(3);
        i_host.rd(8'h06, q); chk(q, 16'h0280);
        @(posedge clk) pm <= 1'b1;
        tick(3);
        i_host.rd(8'h06, q); chk(q, 16'h0290);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        t_reset;
        t_cmd;
        t_serr;
        t_events;
        t_caps;
        print_verdict;
    end
    initial begin
        #200000;
        mismatches++;
        print_verdict;
    end
endmodule // lan_pci_command_status_regs_bench
bind lpc_cmd_sts lpc_cmd_sts_chk u_chk (.*);
`default_nettype wire
